// File: rtl/led_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz system clock, AXI4-Lite byte addresses
// Notes: Definitions only
`ifndef LED_DEFS_SVH
`define LED_DEFS_SVH
`define OFS_CFG 8'h00
`define OFS_LIM 8'h04
`define OFS_DLY 8'h08
`define OFS_STEP 8'h0C
`define OFS_INTV 8'h10
`define OFS_ODLY 8'h14
`define CFG_CTRL_LSB 0
`define CFG_CLKSRC_BIT 2
`define CFG_SYNC_BIT 3
`define CFG_WIDTH_LSB 4
`define CFG_COMMIT_BIT 6
`define CFG_SRST_BIT 7
`define CFG_SPARE_LSB 8
`define CFG_ASYM_BIT 16
`define CFG_SPARE_RST 8'h14
`define REG_RST 32'h0000_0000
`define DLY_LD_LSB 0
`define DLY_HD_LSB 12
`define CNT_MAX_8B 8'hFF
`define CNT_MAX_7B 8'hFE
`define CNT_MAX_6B 8'hFC
`define SYS_CLK_HZ 40000000
`define LF_CLK_HZ 32768
`define LF_DIV_CYC (`SYS_CLK_HZ / `LF_CLK_HZ)
`endif

// File: rtl/led_pkg.sv
// Purpose: Types shared by the LED PWM block
// Assumes: Nothing
// Notes: Gray-coded breathing states
package led_pkg;
   typedef enum logic [1:0] {
      CTRL_OFF = 2'h0,
      CTRL_BREATHE = 2'h1,
      CTRL_BLINK = 2'h2,
      CTRL_ON = 2'h3
   } ctrl_t;
   typedef enum logic [1:0] {
      ST_RISE = 2'h0,
      ST_HOLD_HI = 2'h1,
      ST_FALL = 2'h3,
      ST_HOLD_LO = 2'h2
   } breath_st_t;
endpackage : led_pkg

// File: rtl/regbus_if.sv
// Purpose: Simple register access between bus slave and register file
// Assumes: Decode answers combinationally
// Notes: wr_en is a one-cycle pulse
`timescale 1ns/1ps
interface regbus_if;
   logic wr_en;
   logic [7:0] waddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic werr;
   logic [7:0] raddr;
   logic [31:0] rdata;
   logic rerr;
   modport slave(output wr_en, waddr, wdata, wstrb, raddr,
      input werr, rdata, rerr);
   modport regs(input wr_en, waddr, wdata, wstrb, raddr,
      output werr, rdata, rerr);
endinterface : regbus_if

// File: rtl/axil_slave.sv
// Purpose: AXI4-Lite slave feeding the register access interface
// Assumes: One write and one read outstanding at most
// Notes: Unmapped addresses answer SLVERR
`timescale 1ns/1ps
module axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   regbus_if.slave rb
);
   logic aw_r, w_r, fire;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   assign awready = !aw_r;
   assign wready = !w_r;
   assign fire = aw_r && w_r && !bvalid;
   assign rb.wr_en = fire;
   assign rb.waddr = awaddr_r;
   assign rb.wdata = wdata_r;
   assign rb.wstrb = wstrb_r;
   assign arready = !rvalid;
   assign rb.raddr = araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_r <= 1'b0;
         w_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_r <= 1'b1;
            awaddr_r <= awaddr;
         end else if (fire) begin
            aw_r <= 1'b0;
         end
         if (wvalid && wready) begin
            w_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end else if (fire) begin
            w_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= 2'h0;
      end else if (fire) begin
         bvalid <= 1'b1;
         bresp <= rb.werr ? 2'h2 : 2'h0;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'h0;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= rb.rdata;
         rresp <= rb.rerr ? 2'h2 : 2'h0;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : axil_slave

// File: rtl/lf_tick_div.sv
// Purpose: One-cycle enable at the low-frequency clock rate
// Assumes: 40 MHz system clock
// Notes: Integer divide, so the rate is slightly above 32.768 kHz
`timescale 1ns/1ps
`include "led_defs.svh"
module lf_tick_div (
   input wire logic aclk,
   input wire logic aresetn,
   output logic tick
);
   localparam logic [10:0] DIV_LAST = 11'(`LF_DIV_CYC - 1);
   logic [10:0] div_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= 11'h000;
         tick <= 1'b0;
      end else begin
         tick <= (div_r == DIV_LAST);
         div_r <= (div_r == DIV_LAST) ? 11'h000 : div_r + 11'h001;
      end
   end
endmodule : lf_tick_div

// File: rtl/led_breathing_pwm.sv
// Purpose: Blinking/breathing LED PWM with staged register updates
// Assumes: AXI4-Lite register access, single 40 MHz clock
// Notes: Low-frequency clock is an enable from a divider
`timescale 1ns/1ps
`include "led_defs.svh"
module led_breathing_pwm import led_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic led_out
);
   regbus_if rb();
   ctrl_t ctrl_r;
   breath_st_t st_r;
   logic clk_src_r, sync_r, asym_r, commit_r, led_r, lf_tick;
   logic [1:0] width_r;
   logic [7:0] spare_r, cnt_r, cnt_max, cnt_inc, duty_r, duty;
   logic [31:0] lim_h, dly_h, step_h, intv_h;
   logic [31:0] lim_op, dly_op, step_op, intv_op, odly_r;
   logic [11:0] presc_r, hold_r;
   logic [3:0] ivl_r, seg_step, seg_intv;
   logic [2:0] seg;
   logic srst, rst_all, cfg_we, commit_set, halt;
   logic cnt_adv, period_end, presc_fire, src_en, tick_b;
   logic [8:0] up_sum, dn_dif;

   function automatic logic [31:0] bmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
      end
      return res;
   endfunction : bmerge

   axil_slave u_bus (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .rb(rb)
   );

   lf_tick_div u_lf (.aclk(aclk), .aresetn(aresetn), .tick(lf_tick));

   function automatic logic mapped(input logic [7:0] a);
      return a == `OFS_CFG || a == `OFS_LIM || a == `OFS_DLY ||
         a == `OFS_STEP || a == `OFS_INTV || a == `OFS_ODLY;
   endfunction : mapped

   assign rb.werr = !mapped(rb.waddr);
   assign rb.rerr = !mapped(rb.raddr);
   assign cfg_we = rb.wr_en && rb.waddr == `OFS_CFG;
   assign srst = cfg_we && rb.wstrb[0] && rb.wdata[`CFG_SRST_BIT];
   assign rst_all = !aresetn || srst;
   assign commit_set = cfg_we && rb.wstrb[0] &&
      rb.wdata[`CFG_COMMIT_BIT];

   // Configuration takes effect on the write itself
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         ctrl_r <= CTRL_OFF;
         clk_src_r <= 1'b0;
         sync_r <= 1'b0;
         width_r <= 2'h0;
         spare_r <= `CFG_SPARE_RST;
         asym_r <= 1'b0;
      end else if (cfg_we) begin
         if (rb.wstrb[0]) begin
            ctrl_r <= ctrl_t'(rb.wdata[`CFG_CTRL_LSB +: 2]);
            clk_src_r <= rb.wdata[`CFG_CLKSRC_BIT];
            sync_r <= rb.wdata[`CFG_SYNC_BIT];
            width_r <= rb.wdata[`CFG_WIDTH_LSB +: 2];
         end
         if (rb.wstrb[1]) spare_r <= rb.wdata[`CFG_SPARE_LSB +: 8];
         if (rb.wstrb[2]) asym_r <= rb.wdata[`CFG_ASYM_BIT];
      end
   end

   // A new request wins over the clear, so it waits for the next end
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         commit_r <= 1'b0;
      end else if (commit_set) begin
         commit_r <= 1'b1;
      end else if (period_end && commit_r) begin
         commit_r <= 1'b0;
      end
   end

   // Holding registers take bus writes byte by byte
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         lim_h <= `REG_RST;
         dly_h <= `REG_RST;
         step_h <= `REG_RST;
         intv_h <= `REG_RST;
         odly_r <= `REG_RST;
      end else if (rb.wr_en) begin
         case (rb.waddr)
            `OFS_LIM: lim_h <= bmerge(lim_h, rb.wdata, rb.wstrb) &
               32'h0000_FFFF;
            `OFS_DLY: dly_h <= bmerge(dly_h, rb.wdata, rb.wstrb) &
               32'h00FF_FFFF;
            `OFS_STEP: step_h <= bmerge(step_h, rb.wdata, rb.wstrb);
            `OFS_INTV: intv_h <= bmerge(intv_h, rb.wdata, rb.wstrb);
            `OFS_ODLY: odly_r <= bmerge(odly_r, rb.wdata, rb.wstrb) &
               32'h0000_0FFF;
            default: ;
         endcase
      end
   end

   // Limits follow the holding copy at every period end
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         lim_op <= `REG_RST;
      end else if (period_end) begin
         lim_op <= lim_h;
      end
   end

   // Breathing shape moves as one set, only when committed
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         dly_op <= `REG_RST;
         step_op <= `REG_RST;
         intv_op <= `REG_RST;
      end else if (period_end && commit_r) begin
         dly_op <= dly_h;
         step_op <= step_h;
         intv_op <= intv_h;
      end
   end

   always_comb begin
      case (rb.raddr)
         `OFS_CFG: rb.rdata = {15'h0000, asym_r, spare_r, 1'b0,
            commit_r, width_r, sync_r, clk_src_r, ctrl_r};
         `OFS_LIM: rb.rdata = lim_op;
         `OFS_DLY: rb.rdata = dly_op;
         `OFS_STEP: rb.rdata = step_op;
         `OFS_INTV: rb.rdata = intv_op;
         `OFS_ODLY: rb.rdata = odly_r;
         default: rb.rdata = 32'h0000_0000;
      endcase
   end

   // Blink ignores the width field and always runs 8-bit
   always_comb begin
      if (ctrl_r == CTRL_BLINK) begin
         cnt_max = `CNT_MAX_8B;
         cnt_inc = 8'h01;
      end else begin
         case (width_r)
            2'h1: begin
               cnt_max = `CNT_MAX_7B;
               cnt_inc = 8'h02;
            end
            2'h2: begin
               cnt_max = `CNT_MAX_6B;
               cnt_inc = 8'h04;
            end
            default: begin
               cnt_max = `CNT_MAX_8B;
               cnt_inc = 8'h01;
            end
         endcase
      end
   end

   assign halt = ctrl_r == CTRL_OFF || sync_r;
   assign src_en = clk_src_r ? 1'b1 : lf_tick;
   assign presc_fire = src_en && presc_r == 12'h000;
   assign cnt_adv = !halt &&
      (ctrl_r == CTRL_BLINK ? presc_fire : lf_tick);
   // Wrap when the next step would pass the maximum, so a counter left
   // off-grid by a width change can never overshoot the new ceiling
   assign period_end = cnt_adv && cnt_r > cnt_max - cnt_inc;

   always_ff @(posedge aclk) begin
      if (rst_all || halt || ctrl_r != CTRL_BLINK) begin
         presc_r <= 12'h000;
      end else if (presc_fire) begin
         presc_r <= dly_op[`DLY_LD_LSB +: 12];
      end else if (src_en) begin
         presc_r <= presc_r - 12'h001;
      end
   end

   always_ff @(posedge aclk) begin
      if (rst_all || halt) begin
         cnt_r <= 8'h00;
      end else if (period_end) begin
         cnt_r <= 8'h00;
      end else if (cnt_adv) begin
         cnt_r <= cnt_r + cnt_inc;
      end
   end

   assign seg = asym_r ? {st_r == ST_FALL || st_r == ST_HOLD_HI,
      duty_r[7:6]} : duty_r[7:5];
   assign seg_step = step_op[seg*4 +: 4];
   assign seg_intv = intv_op[seg*4 +: 4];
   assign up_sum = {1'b0, duty_r} + {5'h00, seg_step};
   assign dn_dif = {1'b0, duty_r} - {5'h00, seg_step};
   assign tick_b = period_end && ctrl_r == CTRL_BREATHE;

   // One breathing tick per PWM period; holds count the same ticks
   always_ff @(posedge aclk) begin
      if (rst_all || halt) begin
         st_r <= ST_RISE;
         duty_r <= 8'h00;
         hold_r <= 12'h000;
         ivl_r <= 4'h0;
      end else if (tick_b) begin
         case (st_r)
            ST_RISE: begin
               if (duty_r >= lim_op[15:8]) begin
                  st_r <= ST_HOLD_HI;
                  hold_r <= 12'h000;
               end else if ({1'b0, ivl_r} + 5'h01 >= {1'b0, seg_intv}) begin
                  ivl_r <= 4'h0;
                  duty_r <= up_sum[8] ? 8'hFF : up_sum[7:0];
               end else begin
                  ivl_r <= ivl_r + 4'h1;
               end
            end
            ST_HOLD_HI: begin
               if (hold_r >= dly_op[`DLY_HD_LSB +: 12]) begin
                  st_r <= ST_FALL;
                  ivl_r <= 4'h0;
               end else begin
                  hold_r <= hold_r + 12'h001;
               end
            end
            ST_FALL: begin
               if (duty_r <= lim_op[7:0]) begin
                  st_r <= ST_HOLD_LO;
                  hold_r <= 12'h000;
               end else if ({1'b0, ivl_r} + 5'h01 >= {1'b0, seg_intv}) begin
                  ivl_r <= 4'h0;
                  duty_r <= dn_dif[8] ? 8'h00 : dn_dif[7:0];
               end else begin
                  ivl_r <= ivl_r + 4'h1;
               end
            end
            ST_HOLD_LO: begin
               if (hold_r >= dly_op[`DLY_LD_LSB +: 12]) begin
                  st_r <= ST_RISE;
                  ivl_r <= 4'h0;
               end else begin
                  hold_r <= hold_r + 12'h001;
               end
            end
            default: st_r <= ST_RISE;
         endcase
      end
   end

   // Blink duty is the minimum field, so one byte write retunes it
   assign duty = ctrl_r == CTRL_BLINK ? lim_op[7:0] : duty_r;

   always_ff @(posedge aclk) begin
      if (rst_all) begin
         led_r <= 1'b0;
      end else begin
         case (ctrl_r)
            CTRL_ON: led_r <= 1'b1;
            CTRL_OFF: led_r <= 1'b0;
            default: led_r <= duty == 8'hFF || cnt_r < duty;
         endcase
      end
   end

   assign led_out = led_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_wrap_to_zero: assert property (
      period_end && !srst |=> cnt_r == 8'h00)
      else $error("counter did not wrap at period end");
   a_count_ceiling: assert property (
      cnt_adv && !srst |=> cnt_r <= $past(cnt_max))
      else $error("counter passed its maximum");
   a_cfg_immediate: assert property (
      cfg_we && rb.wstrb[0] && !srst |=>
      ctrl_r == $past(rb.wdata[1:0]) && width_r == $past(rb.wdata[5:4]))
      else $error("configuration write not applied at once");
   a_limit_copy: assert property (
      period_end && !srst |=> lim_op == $past(lim_h))
      else $error("limits not copied at period end");
   a_limit_stable: assert property (
      !period_end && !srst |=> $stable(lim_op))
      else $error("limits changed mid-period");
   a_staged_copy: assert property (
      period_end && commit_r && !srst |=> dly_op == $past(dly_h) &&
      step_op == $past(step_h) && intv_op == $past(intv_h))
      else $error("committed values not copied");
   a_staged_kept: assert property (
      !(period_end && commit_r) && !srst |=> $stable(step_op) &&
      $stable(dly_op) && $stable(intv_op))
      else $error("operating values moved without commit");
   a_commit_clear: assert property (
      period_end && commit_r && !commit_set && !srst |=> !commit_r)
      else $error("commit bit not cleared with copy");
   a_commit_pending: assert property (
      commit_set && !srst |=> commit_r)
      else $error("commit request lost");
   a_soft_reset: assert property (
      srst |=> ctrl_r == CTRL_OFF && lim_op == 32'h0000_0000 &&
      !commit_r && spare_r == `CFG_SPARE_RST)
      else $error("soft reset did not restore defaults");
   a_off_dark: assert property (
      ctrl_r == CTRL_OFF ##1 ctrl_r == CTRL_OFF |-> !led_out &&
      cnt_r == 8'h00)
      else $error("off mode not dark and cleared");

   c_commit_copy: cover property (period_end && commit_r);
   c_hold_high: cover property (tick_b && st_r == ST_HOLD_HI);
   c_blink_end: cover property (period_end && ctrl_r == CTRL_BLINK);
   c_soft_reset: cover property (srst);
endmodule : led_breathing_pwm

// File: verification/led_sink_model.sv
// Purpose: LED pin sink that counts lit cycles over one 256-cycle window
// Assumes: Unprescaled blink, so one PWM period is 256 system clocks
// Notes: Fixed window, so any window alignment gives the same count
`timescale 1ns/1ps
module led_sink_model (
   input wire logic aclk,
   input wire logic led_out,
   input wire logic start,
   output logic done,
   output logic [8:0] high_cnt
);
   int win = 0;
   always @(posedge aclk) begin
      done <= 1'b0;
      if (start) begin
         win <= 256;
         high_cnt <= 9'h000;
      end else if (win > 0) begin
         win <= win - 1;
         high_cnt <= high_cnt + 9'(led_out);
         done <= (win == 1);
      end
   end
endmodule : led_sink_model

// File: verification/led_breathing_pwm_tb_top.sv
// Purpose: Self-checking bench for the LED PWM register and update control
// Assumes: Blink on the system clock with zero prescale, 256-cycle period
// Notes: Waits of 300 cycles cover one full period end
`timescale 1ns/1ps
`include "led_defs.svh"
`define CHK(g, e) \
   begin \
      checks++; \
      if ((g) !== (e)) begin \
         error_cnt++; \
         $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); \
      end \
   end
module led_breathing_pwm_tb_top import led_pkg::*;;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, led_out, start, done;
   logic [7:0] awaddr, araddr, d;
   logic [31:0] wdata, rdata, r;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, exp_wr;
   logic [33:0] exp_rd;
   logic [8:0] high_cnt, exp_led;
   logic [33:0] rd_q[$];
   logic [1:0] wr_q[$];
   logic [8:0] led_q[$];
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   integer seed = 36676;

   led_breathing_pwm dut_u (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .led_out(led_out));
   led_sink_model sink_u (.aclk(aclk), .led_out(led_out), .start(start),
      .done(done), .high_cnt(high_cnt));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic test_done;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // Responses are matched in order against the notes left by the driver
   always @(posedge aclk) begin
      cyc++;
      if (rvalid && rready && rd_q.size() > 0) begin
         exp_rd = rd_q.pop_front();
         `CHK({rresp, rdata}, exp_rd)
      end
      if (bvalid && bready && wr_q.size() > 0) begin
         exp_wr = wr_q.pop_front();
         `CHK(bresp, exp_wr)
      end
      if (done && led_q.size() > 0) begin
         exp_led = led_q.pop_front();
         `CHK(high_cnt, exp_led)
      end
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] dat,
      input logic [3:0] s, input logic [1:0] resp);
      @(posedge aclk);
      wr_q.push_back(resp);
      awaddr <= a;
      wdata <= dat;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      bready <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, input logic [31:0] dat,
      input logic [1:0] resp);
      @(posedge aclk);
      rd_q.push_back({resp, dat});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      rready <= 1'b0;
   endtask : bus_rd

   // Lit cycles over one whole period equal the blink duty, or all 256 when the duty is FF
   task automatic measure(input logic [8:0] e);
      @(posedge aclk);
      led_q.push_back(e);
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      repeat (258) @(posedge aclk);
   endtask : measure

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, start} <= 7'h00;
      {awaddr, araddr, wdata, wstrb} <= 52'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      bus_rd(`OFS_CFG, 32'h0000_1400, 2'h0);
      for (int i = 1; i < 6; i++)
         bus_rd(8'(4 * i), 32'h0, 2'h0);
      bus_rd(8'h18, 32'h0, 2'h2);
      bus_wr(8'h18, 32'hFFFF_FFFF, 4'hF, 2'h2);
      // Off mode has no period end, so the new minimum stays staged
      bus_wr(`OFS_LIM, 32'h0000_C040, 4'h1, 2'h0);
      repeat (300) @(posedge aclk);
      bus_rd(`OFS_LIM, 32'h0, 2'h0);
      bus_wr(`OFS_CFG, 32'h0000_0006, 4'h1, 2'h0);
      bus_rd(`OFS_CFG, 32'h0000_1406, 2'h0);
      repeat (300) @(posedge aclk);
      bus_rd(`OFS_LIM, 32'h0000_0040, 2'h0);
      measure(9'h040);
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         bus_wr(`OFS_LIM, {24'h0, d}, 4'h1, 2'h0);
         repeat (300) @(posedge aclk);
         measure((d == 8'hFF) ? 9'h100 : {1'b0, d});
      end
      bus_wr(`OFS_DLY, 32'h0001_9000, 4'hF, 2'h0);
      for (int i = 0; i < 4; i++)
         bus_wr(`OFS_STEP, 32'hAAAA_AAAA, 4'(1 << i), 2'h0);
      bus_wr(`OFS_INTV, 32'h8888_8888, 4'hF, 2'h0);
      repeat (300) @(posedge aclk);
      bus_rd(`OFS_DLY, 32'h0, 2'h0);
      bus_rd(`OFS_STEP, 32'h0, 2'h0);
      bus_wr(`OFS_CFG, 32'h0000_0040, 4'h1, 2'h0);
      bus_rd(`OFS_CFG, 32'h0000_1440, 2'h0);
      bus_wr(`OFS_CFG, 32'h0000_0000, 4'h1, 2'h0);
      bus_rd(`OFS_CFG, 32'h0000_1440, 2'h0);
      measure(9'h000);
      bus_wr(`OFS_CFG, 32'h0000_0046, 4'h1, 2'h0);
      repeat (300) @(posedge aclk);
      bus_rd(`OFS_CFG, 32'h0000_1406, 2'h0);
      bus_rd(`OFS_DLY, 32'h0001_9000, 2'h0);
      bus_rd(`OFS_STEP, 32'hAAAA_AAAA, 2'h0);
      bus_rd(`OFS_INTV, 32'h8888_8888, 2'h0);
      bus_wr(`OFS_CFG, 32'h0000_0007, 4'h1, 2'h0);
      measure(9'h100);
      bus_wr(`OFS_CFG, 32'h0001_3700, 4'h6, 2'h0);
      bus_rd(`OFS_CFG, 32'h0001_3707, 2'h0);
      for (int w = 0; w < 4; w++) begin
         bus_wr(`OFS_CFG, 32'(w * 16 + 7), 4'h1, 2'h0);
         bus_rd(`OFS_CFG, 32'h0001_3707 | 32'(w * 16), 2'h0);
      end
      r = 32'($random(seed));
      bus_wr(`OFS_ODLY, r, 4'hF, 2'h0);
      bus_rd(`OFS_ODLY, r & 32'h0000_0FFF, 2'h0);
      // Breathing starts from a cleared duty and a zero ceiling, so it stays
      // dark: the duty only moves once per period
      bus_wr(`OFS_CFG, 32'h0000_0001, 4'h1, 2'h0);
      measure(9'h000);
      bus_wr(`OFS_CFG, 32'h0000_0080, 4'h1, 2'h0);
      bus_rd(`OFS_CFG, 32'h0000_1400, 2'h0);
      for (int i = 1; i < 6; i++)
         bus_rd(8'(4 * i), 32'h0, 2'h0);
      repeat (4) @(posedge aclk);
      `CHK(rd_q.size() + wr_q.size() + led_q.size(), 0)
      test_done();
   end
endmodule : led_breathing_pwm_tb_top
